/* src/flash_pin_defs.svh */
`ifndef FLASH_PIN_DEFS_SVH
`define FLASH_PIN_DEFS_SVH

// ----------------------------------------
// Command bytes
// ----------------------------------------
`define CMD_WREN 8'h06
`define CMD_WRDI 8'h04
`define CMD_RDREG_A 8'h0F
`define CMD_RDREG_B 8'h05
`define CMD_WRREG_A 8'h1F
`define CMD_WRREG_B 8'h01
`define CMD_LOAD 8'h02
`define CMD_QLOAD_A 8'h32
`define CMD_QLOAD_B 8'h34
`define CMD_READ 8'h03
`define CMD_FREAD 8'h0B
`define CMD_DREAD 8'h3B
`define CMD_DIOREAD 8'hBB
`define CMD_QREAD 8'h6B
`define CMD_QIOREAD 8'hEB

// ----------------------------------------
// Register addresses and protection register fields
// ----------------------------------------
`define REG_PROT 8'hA0
`define REG_STAT 8'hC0
`define PROT_RESET 8'h78
`define BIT_SPF0 0
`define BIT_WPE 1
`define BIT_TB 2
`define BLK_LSB 3
`define BLK_MSB 6
`define BIT_SPF1 7
`define STAT_BIT_WEL 1

// ----------------------------------------
// Lane widths and phase lengths
// ----------------------------------------
`define W_ONE 3'h1
`define W_TWO 3'h2
`define W_FOUR 3'h4
`define BYTE_BITS 4'h8
`define RD_ADDR_BYTES 2'h3
`define LD_ADDR_BYTES 2'h2
`define RG_ADDR_BYTES 2'h1

// Synchroniser reset: {cs_n, sclk, lane[3:0]}; select reads low so only a real high arms
`define SYNC_RESET 6'h0F

`endif

/* src/flash_pin_pkg.sv */
package flash_pin_pkg;

   typedef logic [3:0] lane_vec_t;
   typedef logic [7:0] byte_t;

   typedef enum logic [4:0]
   {
      ST_CMD = 5'h01,
      ST_ADDR = 5'h02,
      ST_WDATA = 5'h04,
      ST_RDATA = 5'h08,
      ST_IGNORE = 5'h10
   } phase_t;

   typedef enum logic [3:0]
   {
      K_RREG = 4'h1,
      K_WREG = 4'h2,
      K_LOAD = 4'h4,
      K_READ = 4'h8
   } kind_t;

   typedef struct packed
   {
      logic armed;
      logic paused;
      logic quad;
      logic sclk_d;
      phase_t phase;
      kind_t kind;
      logic [2:0] win;
      logic [2:0] wout;
      logic [2:0] wdw;
      logic [7:0] rx;
      logic [3:0] rcnt;
      logic [1:0] acnt;
      logic [15:0] addr;
      logic [7:0] reg_addr;
      logic [7:0] tx;
      logic [3:0] tcnt;
      logic [7:0] pre;
      logic pend;
      logic [7:0] prot;
      logic wel;
      logic [3:0] oe;
      logic [3:0] dout;
      logic rd_req;
      logic [15:0] rd_addr;
      logic wr_valid;
      logic [7:0] wr_data;
      logic reject;
   } core_state_t;

endpackage

/* src/pin_sync.sv */
`timescale 1ns/10ps
module pin_sync
#(
   parameter int WIDTH = 6,
   parameter logic [WIDTH-1:0] RESET_VALUE = '0
)
(
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   typedef struct packed
   {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] held;
   } sync_state_t;

   sync_state_t s;
   sync_state_t next_s;

   always_comb
   begin
      next_s.meta = async_in;
      next_s.held = s.meta;
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         s.meta <= RESET_VALUE;
         s.held <= RESET_VALUE;
      end
      else
      begin
         s <= next_s;
      end
   end

   assign sync_out = s.held;

endmodule

/* src/flash_pin_core.sv */
// Design decisions made here: strobed register access and the placing of the registers.
`timescale 1ns/10ps
`include "flash_pin_defs.svh"
module flash_pin_core
#(
   parameter logic [10:0] ARRAY_BLOCKS = 11'h400
)
(
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic sclk,
   input wire logic cs_n,
   input wire flash_pin_pkg::lane_vec_t lane_i,
   output flash_pin_pkg::lane_vec_t lane_o,
   output flash_pin_pkg::lane_vec_t lane_oe,
   output logic rd_req,
   output logic [15:0] rd_addr,
   input wire flash_pin_pkg::byte_t rd_data,
   output logic wr_valid,
   output flash_pin_pkg::byte_t wr_data,
   output logic write_enabled,
   output flash_pin_pkg::byte_t prot_reg,
   output logic hw_protect,
   output logic [10:0] protect_blocks,
   output logic protect_bottom,
   output logic cmd_reject
);
   import flash_pin_pkg::*;

   // ----------------------------------------
   // Decode helpers
   // ----------------------------------------
   function automatic logic is_quad(input logic [7:0] cmd);
      return (cmd == `CMD_QREAD) || (cmd == `CMD_QIOREAD) ||
             (cmd == `CMD_QLOAD_A) || (cmd == `CMD_QLOAD_B);
   endfunction

   function automatic logic [2:0] data_width(input logic [7:0] cmd);
      logic [2:0] w;
      w = `W_ONE;
      if ((cmd == `CMD_DREAD) || (cmd == `CMD_DIOREAD))
         w = `W_TWO;
      else if (is_quad(cmd))
         w = `W_FOUR;
      return w;
   endfunction

   function automatic logic [2:0] addr_width(input logic [7:0] cmd);
      logic [2:0] w;
      w = `W_ONE;
      if (cmd == `CMD_DIOREAD)
         w = `W_TWO;
      else if (cmd == `CMD_QIOREAD)
         w = `W_FOUR;
      return w;
   endfunction

   // Incoming bits enter at the bottom, lane 3 highest within a group
   function automatic logic [7:0] shift_in(input logic [7:0] rx, input logic [3:0] ln, input logic [2:0] w);
      logic [7:0] r;
      case (w)
         `W_FOUR: r = {rx[3:0], ln};
         `W_TWO: r = {rx[5:0], ln[1:0]};
         default: r = {rx[6:0], ln[0]};
      endcase
      return r;
   endfunction

   function automatic logic [7:0] reg_value(input logic [7:0] a, input logic [7:0] prot, input logic wel);
      logic [7:0] v;
      v = 8'h00;
      if (a == `REG_PROT)
         v = prot;
      else if (a == `REG_STAT)
         v[`STAT_BIT_WEL] = wel;
      return v;
   endfunction

   // Protection register update permitted
   function automatic logic wr_ok(input logic [7:0] prot, input logic wp_n, input logic wel);
      logic ok;
      ok = wel;
      if (prot[`BIT_WPE] && !wp_n)
         ok = 1'b0;
      if (!prot[`BIT_SPF1] && prot[`BIT_SPF0] && !wp_n)
         ok = 1'b0;
      if (prot[`BIT_SPF1])
         ok = 1'b0;
      return ok;
   endfunction

   // Protected span in 128KB blocks: smallest nonzero span is two blocks
   function automatic logic [10:0] span_blocks(input logic [3:0] blk);
      logic [15:0] raw;
      raw = (blk == 4'h0) ? 16'h0000 : (16'h0001 << blk);
      if (raw > {5'h00, ARRAY_BLOCKS})
         raw = {5'h00, ARRAY_BLOCKS};
      return raw[10:0];
   endfunction

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic [5:0] pins_s;
   logic cs_n_s;
   logic sclk_s;
   logic [3:0] lane_s;
   logic wp_n_s;
   logic hold_n_s;

   pin_sync
   #(
      .WIDTH(6),
      .RESET_VALUE(`SYNC_RESET)
   )
   pin_sync_inst
   (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .async_in({cs_n, sclk, lane_i}),
      .sync_out(pins_s)
   );

   assign cs_n_s = pins_s[5];
   assign sclk_s = pins_s[4];
   assign lane_s = pins_s[3:0];
   assign wp_n_s = lane_s[2];
   assign hold_n_s = lane_s[3];

   // ----------------------------------------
   // Edge detection and protection state
   // ----------------------------------------
   core_state_t s;
   core_state_t next_s;
   logic active;
   logic rise;
   logic fall;
   logic hw_lock;
   logic [7:0] rx_next;
   logic [7:0] src;
   logic [3:0] cnt;
   logic [3:0] tbase;

   assign active = s.armed && !cs_n_s && !s.paused;
   // Edges found from levels, so either idle level at select edges is fine
   assign rise = active && sclk_s && !s.sclk_d;
   assign fall = active && !sclk_s && s.sclk_d;
   assign hw_lock = s.prot[`BIT_WPE] && !wp_n_s;
   assign rx_next = shift_in(s.rx, lane_s, s.win);
   assign cnt = s.rcnt + {1'b0, s.win};

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb
   begin
      next_s = s;
      src = s.tx;
      tbase = `BYTE_BITS;
      next_s.rd_req = 1'b0;
      next_s.wr_valid = 1'b0;
      next_s.reject = 1'b0;
      next_s.sclk_d = sclk_s;
      next_s.pend = s.rd_req;
      if (s.pend)
         next_s.pre = rd_data;
      if (cs_n_s)
      begin
         next_s.armed = 1'b1;
         next_s.phase = ST_CMD;
         next_s.rcnt = 4'h0;
         next_s.win = `W_ONE;
         next_s.oe = 4'h0;
         next_s.quad = 1'b0;
         next_s.paused = 1'b0;
      end
      else if (s.armed)
      begin
         if (!sclk_s)
            next_s.paused = !hold_n_s && !s.quad;
         if (rise && (s.phase != ST_RDATA) && (s.phase != ST_IGNORE))
         begin
            next_s.rx = rx_next;
            next_s.rcnt = (cnt == `BYTE_BITS) ? 4'h0 : cnt;
            if (cnt == `BYTE_BITS)
            begin
               case (s.phase)
                  ST_CMD:
                  begin
                     next_s.phase = ST_IGNORE;
                     case (rx_next)
                        `CMD_WREN:
                        begin
                           if (!hw_lock)
                              next_s.wel = 1'b1;
                        end
                        `CMD_WRDI:
                        begin
                           next_s.wel = 1'b0;
                        end
                        `CMD_RDREG_A, `CMD_RDREG_B:
                        begin
                           next_s.kind = K_RREG;
                           next_s.acnt = `RG_ADDR_BYTES;
                           next_s.phase = ST_ADDR;
                        end
                        `CMD_WRREG_A, `CMD_WRREG_B:
                        begin
                           next_s.kind = K_WREG;
                           next_s.acnt = `RG_ADDR_BYTES;
                           next_s.phase = ST_ADDR;
                        end
                        `CMD_LOAD, `CMD_QLOAD_A, `CMD_QLOAD_B:
                        begin
                           if (!s.wel || hw_lock || (is_quad(rx_next) && s.prot[`BIT_WPE]))
                           begin
                              next_s.reject = 1'b1;
                           end
                           else
                           begin
                              next_s.kind = K_LOAD;
                              next_s.acnt = `LD_ADDR_BYTES;
                              next_s.wdw = data_width(rx_next);
                              next_s.quad = is_quad(rx_next);
                              next_s.phase = ST_ADDR;
                           end
                        end
                        `CMD_READ, `CMD_FREAD, `CMD_DREAD, `CMD_DIOREAD, `CMD_QREAD, `CMD_QIOREAD:
                        begin
                           if (is_quad(rx_next) && s.prot[`BIT_WPE])
                           begin
                              next_s.reject = 1'b1;
                           end
                           else
                           begin
                              next_s.kind = K_READ;
                              next_s.acnt = `RD_ADDR_BYTES;
                              next_s.win = addr_width(rx_next);
                              next_s.wout = data_width(rx_next);
                              next_s.quad = is_quad(rx_next);
                              next_s.phase = ST_ADDR;
                           end
                        end
                        default:
                        begin
                           next_s.phase = ST_IGNORE;
                        end
                     endcase
                  end
                  ST_ADDR:
                  begin
                     if ((s.kind != K_READ) || (s.acnt != 2'h1))
                        next_s.addr = {s.addr[7:0], rx_next};
                     next_s.reg_addr = rx_next;
                     next_s.acnt = s.acnt - 2'h1;
                     if (s.acnt == 2'h1)
                     begin
                        next_s.tcnt = 4'h0;
                        case (s.kind)
                           K_RREG:
                           begin
                              next_s.pre = reg_value(rx_next, s.prot, s.wel);
                              next_s.wout = `W_ONE;
                              next_s.phase = ST_RDATA;
                           end
                           K_WREG:
                           begin
                              next_s.phase = ST_WDATA;
                           end
                           K_LOAD:
                           begin
                              next_s.win = s.wdw;
                              next_s.phase = ST_WDATA;
                           end
                           K_READ:
                           begin
                              next_s.rd_req = 1'b1;
                              next_s.rd_addr = s.addr;
                              next_s.addr = s.addr + 16'h0001;
                              next_s.phase = ST_RDATA;
                           end
                           default:
                           begin
                              next_s.phase = ST_IGNORE;
                           end
                        endcase
                     end
                  end
                  ST_WDATA:
                  begin
                     if (s.kind == K_WREG)
                     begin
                        if ((s.reg_addr == `REG_PROT) && wr_ok(s.prot, wp_n_s, s.wel))
                           next_s.prot = rx_next;
                        else
                           next_s.reject = 1'b1;
                        next_s.phase = ST_IGNORE;
                     end
                     else if (hw_lock)
                     begin
                        next_s.reject = 1'b1;
                     end
                     else
                     begin
                        next_s.wr_valid = 1'b1;
                        next_s.wr_data = rx_next;
                     end
                  end
                  default:
                  begin
                     next_s.phase = ST_IGNORE;
                  end
               endcase
            end
         end
         if (fall && (s.phase == ST_RDATA))
         begin
            if (s.tcnt == 4'h0)
            begin
               src = s.pre;
               if (s.kind == K_READ)
               begin
                  next_s.rd_req = 1'b1;
                  next_s.rd_addr = s.addr;
                  next_s.addr = s.addr + 16'h0001;
               end
            end
            else
            begin
               tbase = s.tcnt;
            end
            case (s.wout)
               `W_FOUR:
               begin
                  next_s.dout = src[7:4];
                  next_s.oe = 4'hF;
               end
               `W_TWO:
               begin
                  next_s.dout = {2'h0, src[7:6]};
                  next_s.oe = 4'h3;
               end
               default:
               begin
                  next_s.dout = {2'h0, src[7], 1'b0};
                  next_s.oe = 4'h2;
               end
            endcase
            next_s.tx = src << s.wout;
            next_s.tcnt = tbase - {1'b0, s.wout};
         end
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         s <= '0;
         s.phase <= ST_CMD;
         s.kind <= K_READ;
         s.win <= `W_ONE;
         s.wout <= `W_ONE;
         s.wdw <= `W_ONE;
         s.prot <= `PROT_RESET;
      end
      else
      begin
         s <= next_s;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign lane_o = s.dout;
   assign lane_oe = s.paused ? 4'h0 : s.oe;
   assign rd_req = s.rd_req;
   assign rd_addr = s.rd_addr;
   assign wr_valid = s.wr_valid;
   assign wr_data = s.wr_data;
   assign write_enabled = s.wel;
   assign prot_reg = s.prot;
   assign hw_protect = s.prot[`BIT_WPE];
   assign protect_blocks = span_blocks(s.prot[`BLK_MSB:`BLK_LSB]);
   assign protect_bottom = s.prot[`BIT_TB];
   assign cmd_reject = s.reject;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   AST_DESEL_HIGHZ: assert property (@(posedge core_clk) disable iff (sys_rst)
      cs_n_s |=> (lane_oe == 4'h0))
      else $error("lanes driven while deselected");

   AST_NOT_ARMED: assert property (@(posedge core_clk) disable iff (sys_rst)
      !s.armed |-> (s.phase == ST_CMD) && (lane_oe == 4'h0) && !s.wr_valid)
      else $error("activity before first select");

   AST_CS_RESET: assert property (@(posedge core_clk) disable iff (sys_rst)
      $rose(cs_n_s) |=> (s.phase == ST_CMD) && (s.rcnt == 4'h0) && !s.paused)
      else $error("decoder not reset by select rise");

   AST_RISE_SAMPLE: assert property (@(posedge core_clk) disable iff (sys_rst)
      (rise && (s.phase == ST_CMD)) |=> (s.rx[0] == $past(lane_s[0])))
      else $error("serial input not sampled on rising clock");

   AST_SINGLE_OUT: assert property (@(posedge core_clk) disable iff (sys_rst)
      (fall && (s.phase == ST_RDATA) && (s.wout == `W_ONE)) |=> (lane_oe == 4'h2) ##1 $stable(lane_o))
      else $error("single lane output not on lane 1");

   AST_HW_LOCK: assert property (@(posedge core_clk) disable iff (sys_rst)
      (s.prot[`BIT_WPE] && !wp_n_s) |=> $stable(s.prot) && !s.wr_valid)
      else $error("write while hardware protected");

   AST_QUAD_REJECT: assert property (@(posedge core_clk) disable iff (sys_rst)
      s.prot[`BIT_WPE] |-> !s.quad)
      else $error("quad operation while protect enable set");

   AST_PAUSE_ENTRY: assert property (@(posedge core_clk) disable iff (sys_rst)
      (s.armed && !cs_n_s && !sclk_s && !hold_n_s && !s.quad) |=> s.paused && (lane_oe == 4'h0))
      else $error("pause not entered");

   AST_PAUSE_EXIT: assert property (@(posedge core_clk) disable iff (sys_rst)
      (s.paused && !cs_n_s && !sclk_s && hold_n_s) |=> !s.paused)
      else $error("pause not released");

   AST_PAUSE_KEEP: assert property (@(posedge core_clk) disable iff (sys_rst)
      (s.paused && $past(s.paused) && !cs_n_s) |-> $stable(s.phase) && $stable(s.rx) && $stable(s.rcnt))
      else $error("state lost while paused");

   AST_QUAD_NO_PAUSE: assert property (@(posedge core_clk) disable iff (sys_rst)
      (s.quad && !cs_n_s) |=> !s.paused)
      else $error("pause during quad command");

endmodule

/* verification/spi_host_model.sv */
`timescale 1ns/10ps
// ----------------------------------------
// Host controller model
// ----------------------------------------
module spi_host_model
(
   input wire logic core_clk,
   input wire logic [3:0] lane_in,
   output logic sclk,
   output logic cs_n,
   output logic [3:0] h_val,
   output logic [3:0] h_oe
);
   logic mode3 = 1'b0;
   logic wp_n = 1'b1;
   logic hold_n = 1'b1;
   logic q = 1'b0;
   logic [3:0] dm = 4'h1;
   logic [3:0] dv = 4'h0;
   assign h_oe = q ? dm : (dm | 4'hC);
   assign h_val = q ? dv : {hold_n, wp_n, dv[1:0]};
   initial
   begin
      sclk = 1'b0;
      cs_n = 1'b0;
   end
   task tick(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   // Data set with the falling edge, read back at the rising edge
   task xfer(input int w, input int nb, input logic [7:0] d, input logic drv, output logic [7:0] r);
      int i;
      logic [7:0] s;
      r = 8'h00;
      q <= (w == 4);
      for (i = 0; i < nb; i += w)
      begin
         s = d << i;
         sclk <= 1'b0;
         dm <= drv ? 4'hF >> (4 - w) : {3'h0, w == 1};
         dv <= 4'(s >> (8 - w));
         tick(10);
         sclk <= 1'b1;
         tick(1);
         // Single mode answers on lane 1, wider modes on the low lanes
         r = (r << w) | 8'((w == 1) ? {3'h0, lane_in[1]} : (lane_in & (4'hF >> (4 - w))));
         tick(9);
      end
   endtask
   task cmd(input logic m3, input int nb, input logic [7:0] c);
      logic [7:0] r;
      mode3 = m3;
      sclk <= m3;
      tick(12);
      cs_n <= 1'b0;
      tick(10);
      xfer(1, nb, c, 1'b1, r);
   endtask
   task frame_end;
      sclk <= mode3;
      tick(10);
      cs_n <= 1'b1;
      q <= 1'b0;
      dm <= 4'h1;
      tick(12);
   endtask
   task pause(input int n);
      sclk <= 1'b0;
      tick(10);
      hold_n <= 1'b0;
      tick(10);
      repeat (n)
      begin
         sclk <= 1'b1;
         tick(10);
         sclk <= 1'b0;
         tick(10);
      end
      hold_n <= 1'b1;
      tick(10);
   endtask
endmodule

/* verification/tb_serial_flash_spi_pin_interface.sv */
`timescale 1ns/10ps
`include "flash_pin_defs.svh"
module tb_serial_flash_spi_pin_interface;
   import flash_pin_pkg::*;
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic sclk, cs_n, rd_req, wr_valid, write_enabled, hw_protect, protect_bottom, cmd_reject;
   lane_vec_t lane_w, lane_o, lane_oe, h_val, h_oe;
   logic [15:0] rd_addr;
   logic [10:0] protect_blocks;
   byte_t rd_data = 8'h00;
   byte_t last_wr = 8'h00;
   byte_t wr_data, prot_reg, rx, d2;
   int n_rej = 0;
   int fails = 0;
   int n_checks = 0;
   int k;
   byte_t cmds [6] = '{`CMD_READ, `CMD_FREAD, `CMD_DREAD, `CMD_DIOREAD, `CMD_QREAD, `CMD_QIOREAD};
   int aws [6] = '{1, 1, 1, 2, 1, 4};
   int dws [6] = '{1, 1, 2, 2, 4, 4};
   always #2 core_clk = ~core_clk;
   // Released data lanes show the inverse of the last value, lanes 2 and 3 are pulled up
   assign lane_w = (lane_oe & lane_o) | (~lane_oe & h_oe & h_val) | (~lane_oe & ~h_oe & {2'b11, ~lane_o[1:0]});
   spi_host_model host (.core_clk, .lane_in(lane_w), .sclk, .cs_n, .h_val, .h_oe);
   flash_pin_core flash_pin_core_inst (.core_clk, .sys_rst, .sclk, .cs_n, .lane_i(lane_w), .lane_o, .lane_oe,
      .rd_req, .rd_addr, .rd_data, .wr_valid, .wr_data, .write_enabled, .prot_reg, .hw_protect, .protect_blocks,
      .protect_bottom, .cmd_reject);
   // ----------------------------------------
   // Array side responder and monitors
   // ----------------------------------------
   always @(posedge core_clk)
   begin
      if (rd_req)
         rd_data <= rd_addr[15:8] ^ rd_addr[7:0];
      if (wr_valid)
         last_wr <= wr_data;
      if (cmd_reject)
         n_rej <= n_rej + 1;
   end
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task finish_test;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task wreg(input byte_t v);
      host.cmd(1'b0, 8, `CMD_WRREG_A);
      host.xfer(1, 8, `REG_PROT, 1'b1, rx);
      host.xfer(1, 8, v, 1'b1, rx);
      host.frame_end;
   endtask
   task rd(input byte_t c, input int aw, input int dw, input int nb, input logic [15:0] a, output byte_t d);
      host.cmd(1'b0, 8, c);
      host.xfer(aw, 8, a[15:8], 1'b1, rx);
      host.xfer(aw, 8, a[7:0], 1'b1, rx);
      host.xfer(aw, 8, 8'h00, 1'b1, rx);
      host.xfer(dw, nb, 8'h00, 1'b0, d);
   endtask
   task load(input byte_t c, input int w, input byte_t v);
      host.cmd(1'b0, 8, c);
      host.xfer(1, 8, 8'h00, 1'b1, rx);
      host.xfer(1, 8, 8'h10, 1'b1, rx);
      host.xfer(w, 8, v, 1'b1, rx);
      host.frame_end;
   endtask
   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial
   begin
      repeat (5) @(posedge core_clk);
      sys_rst <= 1'b0;
      @(posedge core_clk);
      #1;
      check("prot_reg", prot_reg, 8'h78);
      check("hw_protect", hw_protect, 1'b0);
      check("protect_blocks", protect_blocks, 11'h400);
      check("lane_oe", lane_oe, 4'h0);
      check("protect_bottom", protect_bottom, 1'b0);
      @(posedge core_clk);
      host.xfer(1, 8, `CMD_WREN, 1'b1, rx);
      host.frame_end;
      check("wel unarmed", write_enabled, 1'b0);
      host.cmd(1'b1, 8, `CMD_WREN);
      host.frame_end;
      check("wel", write_enabled, 1'b1);
      host.cmd(1'b0, 4, 8'h00);
      host.frame_end;
      host.cmd(1'b0, 8, `CMD_WRDI);
      host.frame_end;
      check("wel cleared", write_enabled, 1'b0);
      host.cmd(1'b0, 8, `CMD_WREN);
      host.frame_end;
      host.cmd(1'b0, 8, `CMD_RDREG_A);
      host.xfer(1, 8, `REG_PROT, 1'b1, rx);
      host.xfer(1, 8, 8'h00, 1'b0, rx);
      check("reg read", rx, 8'h78);
      check("lane_oe single", lane_oe, 4'h2);
      host.frame_end;
      check("lane_oe idle", lane_oe, 4'h0);
      host.cmd(1'b0, 8, `CMD_RDREG_B);
      host.xfer(1, 8, `REG_STAT, 1'b1, rx);
      host.xfer(1, 8, 8'h00, 1'b0, rx);
      host.frame_end;
      check("status read", rx, 8'h02);
      wreg(8'h00);
      check("blocks none", protect_blocks, 11'h000);
      wreg(8'h0C);
      check("blocks two", protect_blocks, 11'h002);
      check("bottom", protect_bottom, 1'b1);
      for (k = 0; k < 6; k++)
      begin
         rd(cmds[k], aws[k], dws[k], 8, 16'h1234 + 16'(k), rx);
         host.frame_end;
         check("read", rx, 8'h12 ^ 8'(8'h34 + k));
      end
      load(`CMD_QLOAD_A, 4, 8'h5C);
      check("quad load", last_wr, 8'h5C);
      load(`CMD_QLOAD_B, 4, 8'hA5);
      check("quad load b", last_wr, 8'hA5);
      load(`CMD_LOAD, 1, 8'hC3);
      check("single load", last_wr, 8'hC3);
      rd(`CMD_READ, 1, 1, 4, 16'h00A6, rx);
      fork
         host.pause(3);
         begin
            repeat (40) @(posedge core_clk);
            #1;
            check("lane_oe paused", lane_oe, 4'h0);
         end
      join
      host.xfer(1, 4, 8'h00, 1'b0, d2);
      host.frame_end;
      check("paused read", {rx[3:0], d2[3:0]}, 8'hA6);
      wreg(8'h02);
      check("hw_protect set", hw_protect, 1'b1);
      rd(`CMD_QREAD, 1, 4, 8, 16'h0000, rx);
      host.frame_end;
      check("quad refused", n_rej, 1);
      host.wp_n <= 1'b0;
      host.cmd(1'b0, 8, `CMD_LOAD);
      host.frame_end;
      check("load refused", n_rej, 2);
      wreg(8'h00);
      check("reg write refused", n_rej, 3);
      check("prot kept", prot_reg, 8'h02);
      finish_test;
   end
   initial
   begin
      repeat (50000) @(posedge core_clk);
      fails++;
      finish_test;
   end
endmodule
